// ===== core/dual_timer_counter_modes.v
// Dual 16-bit timer/counter with four modes, control flags and reload registers
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "dual_timer_map.vh"

module dual_timer_counter_modes #(
    parameter ADDR_W = `TMR_ADDR_W          // Register address width
) (
    input  wire              clk,           // System clock, oscillator
    input  wire              reset_n,       // Async reset, active low
    input  wire              clkEn,         // Freezes all state when low
    input  wire [ADDR_W-1:0] regAddr,       // Register address
    input  wire [7:0]        regWrData,     // Register write data
    input  wire              regWr,         // Write strobe
    input  wire              regRd,         // Read strobe
    output reg  [7:0]        regRdData,     // Read data, cycle after strobe
    input  wire              countPin0,     // Timer 0 external count input
    input  wire              countPin1,     // Timer 1 external count input
    input  wire              extIrq0Pin,    // External interrupt 0 pin
    input  wire              extIrq1Pin,    // External interrupt 1 pin
    input  wire              irq0Ack,       // Interrupt 0 vectoring pulse
    input  wire              irq1Ack,       // Interrupt 1 vectoring pulse
    input  wire              timer0Ack,     // Timer 0 vectoring pulse
    input  wire              timer1Ack,     // Timer 1 vectoring pulse
    output wire              timer0Irq,     // Timer 0 overflow flag level
    output wire              timer1Irq,     // Timer 1 overflow flag level
    output wire              extIrq0Req,    // Interrupt 0 request level
    output wire              extIrq1Req     // Interrupt 1 request level
);

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    reg  [7:0] ctrl_q;                      // Timer control flags
    reg  [7:0] modeSel_q;                   // Timer mode select
    reg  [7:0] prescale_q;                  // Prescale select
    reg  [7:0] outStat_q;                   // Timer output status
    reg  [7:0] cntLo0_q, cntHi0_q;          // Timer 0 count bytes
    reg  [7:0] cntLo1_q, cntHi1_q;          // Timer 1 count bytes
    reg  [7:0] relLo0_q, relHi0_q;          // Timer 0 reload bytes
    reg  [7:0] relLo1_q, relHi1_q;          // Timer 1 reload bytes
    reg  [5:0] divCnt_q;                    // Base clock divider
    reg        sampPh_q;                    // Two-cycle sample phase
    reg  [1:0] pin0Sync_q, pin1Sync_q;      // Count pin synchronisers
    reg  [1:0] irq0Sync_q, irq1Sync_q;      // Interrupt pin synchronisers
    reg        pin0Samp_q, pin1Samp_q;      // Sampled count pin levels
    reg        irq0Prev_q, irq1Prev_q;      // Previous interrupt levels

    wire [1:0] mode0 = modeSel_q[`TM_MHI:`TM_MLO];       // Timer 0 mode
    wire [1:0] mode1 = modeSel_q[4+`TM_MHI:4+`TM_MLO];   // Timer 1 mode

    ////////////////////////////////////////////////////////////////////////////////
    // Functions

    // Gating: run bit, optionally qualified by pin level
    function runGate;
        input gate;
        input run;
        input pin;
        begin
            runGate = run & (~gate | pin);
        end
    endfunction

    // Divider terminal count per prescale code
    function [5:0] divTop;
        input [1:0] ps;
        begin
            case (ps)
                `PS_DIV16: divTop = `DIV16_COUNT;
                `PS_DIV64: divTop = `DIV64_COUNT;
                default:   divTop = `DIV4_COUNT;  // Reserved code acts as /4
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Base clock and input sampling

    wire [1:0] psSel   = prescale_q[`PS_HIGH:`PS_LOW];
    wire       baseTick = clkEn & (divCnt_q >= divTop(psSel));
    wire       sampTick = clkEn & sampPh_q;
    wire       fall0 = sampTick & pin0Samp_q & ~pin0Sync_q[1];
    wire       fall1 = sampTick & pin1Samp_q & ~pin1Sync_q[1];
    wire       irq0Edge = irq0Prev_q & ~irq0Sync_q[1];
    wire       irq1Edge = irq1Prev_q & ~irq1Sync_q[1];

    // Divider, sample phase and synchronisers
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            divCnt_q   <= 6'h00;
            sampPh_q   <= 1'b0;
            pin0Sync_q <= 2'h3;
            pin1Sync_q <= 2'h3;
            irq0Sync_q <= 2'h3;
            irq1Sync_q <= 2'h3;
            pin0Samp_q <= 1'b1;
            pin1Samp_q <= 1'b1;
            irq0Prev_q <= 1'b1;
            irq1Prev_q <= 1'b1;
        end else if (clkEn) begin
            divCnt_q   <= baseTick ? 6'h00 : divCnt_q + 6'h01;
            sampPh_q   <= sampPh_q ^ `SAMPLE_PERIOD;
            pin0Sync_q <= {pin0Sync_q[0], countPin0};
            pin1Sync_q <= {pin1Sync_q[0], countPin1};
            irq0Sync_q <= {irq0Sync_q[0], extIrq0Pin};
            irq1Sync_q <= {irq1Sync_q[0], extIrq1Pin};
            irq0Prev_q <= irq0Sync_q[1];
            irq1Prev_q <= irq1Sync_q[1];
            if (sampPh_q) begin
                // Sampled once per two cycles; a level shorter than that may be missed
                pin0Samp_q <= pin0Sync_q[1];
                pin1Samp_q <= pin1Sync_q[1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Count enables

    wire gate0 = runGate(modeSel_q[`TM_GATE], ctrl_q[`TC_TR0], irq0Sync_q[1]);
    wire gate1 = runGate(modeSel_q[4+`TM_GATE], ctrl_q[`TC_TR1], irq1Sync_q[1]);
    wire src0  = modeSel_q[`TM_CT] ? fall0 : baseTick;
    wire src1  = modeSel_q[4+`TM_CT] ? fall1 : baseTick;
    wire inc0  = gate0 & src0;
    // Split mode high byte: base clock only, timer 1 run bit
    wire incHi0Split = (mode0 == `MODE_SPLIT8) & ctrl_q[`TC_TR1] & baseTick;
    // Timer 1 stops in its own mode 3, regardless of run bit
    wire inc1 = gate1 & src1 & (mode1 != `MODE_SPLIT8);

    // Overflow conditions per timer
    wire t0LoFull = (cntLo0_q == 8'hff);
    wire t0HiFull = (cntHi0_q == 8'hff);
    wire t1LoFull = (cntLo1_q == 8'hff);
    wire t1HiFull = (cntHi1_q == 8'hff);
    wire ovf0 = inc0 & t0LoFull & ((mode0[1]) | t0HiFull);
    wire ovf0Hi = incHi0Split & t0HiFull;
    wire ovf1 = inc1 & t1LoFull & ((mode1[1]) | t1HiFull);
    // Timer 1 flag comes from split high byte while timer 0 is in mode 3
    wire set1Src = (mode0 == `MODE_SPLIT8) ? ovf0Hi : ovf1;
    wire setTf1  = set1Src & ~outStat_q[`OS_TIMER1_TOGGLE_OUT_ENABLE];

    wire wrHit = clkEn & regWr;
    wire wrCtrl = wrHit & (regAddr == `TMR_CTRL_OFS);
    wire ackWr  = wrHit & (regAddr == `TMR_IRQACK_OFS);

    ////////////////////////////////////////////////////////////////////////////////
    // Control flags; hardware set wins over clear

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= `TMR_RESET_BYTE;
        end else if (clkEn) begin
            if (wrCtrl) begin
                ctrl_q <= regWrData;
            end
            if (timer1Ack) begin
                ctrl_q[`TC_TF1] <= 1'b0;
            end
            if (timer0Ack) begin
                ctrl_q[`TC_TF0] <= 1'b0;
            end
            if (irq1Ack) begin
                ctrl_q[`TC_IE1] <= 1'b0;
            end
            if (irq0Ack) begin
                ctrl_q[`TC_IE0] <= 1'b0;
            end
            if (setTf1) begin
                ctrl_q[`TC_TF1] <= 1'b1;
            end
            if (ovf0) begin
                ctrl_q[`TC_TF0] <= 1'b1;
            end
            // Edge mode only; level mode requests follow the pin directly
            if (irq1Edge & ctrl_q[`TC_IT1]) begin
                ctrl_q[`TC_IE1] <= 1'b1;
            end
            if (irq0Edge & ctrl_q[`TC_IT0]) begin
                ctrl_q[`TC_IE0] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration and reload registers

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            modeSel_q  <= `TMR_RESET_BYTE;
            prescale_q <= `TMR_RESET_BYTE;
            outStat_q  <= `TMR_RESET_BYTE;
            relLo0_q   <= `TMR_RESET_BYTE;
            relHi0_q   <= `TMR_RESET_BYTE;
            relLo1_q   <= `TMR_RESET_BYTE;
            relHi1_q   <= `TMR_RESET_BYTE;
        end else if (wrHit) begin
            case (regAddr)
                `TMR_MODE_OFS:     modeSel_q  <= regWrData;
                `TMR_PRESCALE_OFS: prescale_q <= regWrData;
                `TMR_OUTSTAT_OFS:  outStat_q  <= regWrData;
                `TMR_R0LOW_OFS:    relLo0_q   <= regWrData;
                `TMR_R0HIGH_OFS:   relHi0_q   <= regWrData;
                `TMR_R1LOW_OFS:    relLo1_q   <= regWrData;
                `TMR_R1HIGH_OFS:   relHi1_q   <= regWrData;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Timer 0 count bytes; a software write beats a count in the same cycle

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cntLo0_q <= `TMR_RESET_BYTE;
            cntHi0_q <= `TMR_RESET_BYTE;
        end else if (clkEn) begin
            if (inc0) begin
                case (mode0)
                    `MODE_RELOAD16: begin
                        if (ovf0) begin
                            cntLo0_q <= relLo0_q;
                            cntHi0_q <= relHi0_q;
                        end else begin
                            cntLo0_q <= cntLo0_q + 8'h01;
                            cntHi0_q <= cntHi0_q + {7'h00, t0LoFull};
                        end
                    end
                    `MODE_FREE16: begin
                        cntLo0_q <= cntLo0_q + 8'h01;
                        cntHi0_q <= cntHi0_q + {7'h00, t0LoFull};
                    end
                    `MODE_RELOAD8: begin
                        cntLo0_q <= ovf0 ? relLo0_q : cntLo0_q + 8'h01;
                    end
                    default: begin
                        cntLo0_q <= cntLo0_q + 8'h01;
                    end
                endcase
            end
            if (incHi0Split) begin
                cntHi0_q <= cntHi0_q + 8'h01;
            end
            if (wrHit && regAddr == `TMR_T0LOW_OFS) begin
                cntLo0_q <= regWrData;
            end
            if (wrHit && regAddr == `TMR_T0HIGH_OFS) begin
                cntHi0_q <= regWrData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Timer 1 count bytes

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cntLo1_q <= `TMR_RESET_BYTE;
            cntHi1_q <= `TMR_RESET_BYTE;
        end else if (clkEn) begin
            if (inc1) begin
                case (mode1)
                    `MODE_RELOAD16: begin
                        if (ovf1) begin
                            cntLo1_q <= relLo1_q;
                            cntHi1_q <= relHi1_q;
                        end else begin
                            cntLo1_q <= cntLo1_q + 8'h01;
                            cntHi1_q <= cntHi1_q + {7'h00, t1LoFull};
                        end
                    end
                    `MODE_RELOAD8: begin
                        cntLo1_q <= ovf1 ? relLo1_q : cntLo1_q + 8'h01;
                    end
                    default: begin
                        cntLo1_q <= cntLo1_q + 8'h01;
                        cntHi1_q <= cntHi1_q + {7'h00, t1LoFull};
                    end
                endcase
            end
            if (wrHit && regAddr == `TMR_T1LOW_OFS) begin
                cntLo1_q <= regWrData;
            end
            if (wrHit && regAddr == `TMR_T1HIGH_OFS) begin
                cntHi1_q <= regWrData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read port; unmapped addresses read zero

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            regRdData <= 8'h00;
        end else if (clkEn) begin
            if (regRd) begin
                case (regAddr)
                    `TMR_CTRL_OFS:     regRdData <= ctrl_q;
                    `TMR_MODE_OFS:     regRdData <= modeSel_q;
                    `TMR_PRESCALE_OFS: regRdData <= prescale_q;
                    `TMR_OUTSTAT_OFS:  regRdData <= outStat_q;
                    `TMR_T0LOW_OFS:    regRdData <= cntLo0_q;
                    `TMR_T0HIGH_OFS:   regRdData <= cntHi0_q;
                    `TMR_T1LOW_OFS:    regRdData <= cntLo1_q;
                    `TMR_T1HIGH_OFS:   regRdData <= cntHi1_q;
                    `TMR_R0LOW_OFS:    regRdData <= relLo0_q;
                    `TMR_R0HIGH_OFS:   regRdData <= relHi0_q;
                    `TMR_R1LOW_OFS:    regRdData <= relLo1_q;
                    `TMR_R1HIGH_OFS:   regRdData <= relHi1_q;
                    default:           regRdData <= 8'h00;
                endcase
            end else begin
                regRdData <= 8'h00;
            end
        end
    end

    // Interrupt request levels
    assign timer0Irq  = ctrl_q[`TC_TF0];
    assign timer1Irq  = ctrl_q[`TC_TF1];
    assign extIrq0Req = ctrl_q[`TC_IT0] ? ctrl_q[`TC_IE0] : ~irq0Sync_q[1];
    assign extIrq1Req = ctrl_q[`TC_IT1] ? ctrl_q[`TC_IE1] : ~irq1Sync_q[1];

endmodule

// ===== core/dual_timer_map.vh
// Register offsets, field positions, reset values and timing counts of the dual timer
`ifndef DUAL_TIMER_MAP_VH
`define DUAL_TIMER_MAP_VH
`define TMR_ADDR_W        12
`define TMR_CTRL_OFS      12'h410
`define TMR_MODE_OFS      12'h45c
`define TMR_PRESCALE_OFS  12'h440
`define TMR_OUTSTAT_OFS   12'h420
`define TMR_T0LOW_OFS     12'h450
`define TMR_T0HIGH_OFS    12'h451
`define TMR_T1LOW_OFS     12'h452
`define TMR_T1HIGH_OFS    12'h453
`define TMR_R0LOW_OFS     12'h454
`define TMR_R0HIGH_OFS    12'h455
`define TMR_R1LOW_OFS     12'h456
`define TMR_R1HIGH_OFS    12'h457
`define TMR_IRQACK_OFS    12'h458
`define TMR_RESET_BYTE    8'h00
`define TC_TF1            7
`define TC_TR1            6
`define TC_TF0            5
`define TC_TR0            4
`define TC_IE1            3
`define TC_IT1            2
`define TC_IE0            1
`define TC_IT0            0
`define TM_GATE           3
`define TM_CT             2
`define TM_MHI            1
`define TM_MLO            0
`define PS_HIGH           3
`define PS_LOW            2
`define OS_TIMER1_TOGGLE_OUT_ENABLE           2
`define MODE_RELOAD16     2'h0
`define MODE_FREE16       2'h1
`define MODE_RELOAD8      2'h2
`define MODE_SPLIT8       2'h3
`define PS_DIV4           2'h0
`define PS_DIV16          2'h1
`define PS_DIV64          2'h2
`define DIV4_COUNT        6'h03
`define DIV16_COUNT       6'h0f
`define DIV64_COUNT       6'h3f
`define SAMPLE_PERIOD     1'h1
`endif

// ===== tb/dual_timer_checker.sv
// Port-level assertions of the dual timer/counter
`timescale 1ns/1ps
`include "dual_timer_map.vh"
module dual_timer_checker #(
    parameter ADDR_W = 12                   // Register address width
) (
    input logic              clk,           // Oscillator clock
    input logic              reset_n,       // Async reset, active low
    input logic              clkEn,         // Global freeze when low
    input logic [ADDR_W-1:0] regAddr,       // Register address
    input logic [7:0]        regWrData,     // Write data
    input logic              regWr,         // Write strobe
    input logic              regRd,         // Read strobe
    input logic [7:0]        regRdData,     // Read data
    input logic              timer0Ack,     // Timer 0 vectoring pulse
    input logic              timer1Ack,     // Timer 1 vectoring pulse
    input logic              timer0Irq,     // Timer 0 flag level
    input logic              timer1Irq      // Timer 1 flag level
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Software write to the control byte may clear flags, so holds exclude it
    wire ctlWr = clkEn && regWr && (regAddr == `TMR_CTRL_OFS);

    ////////////////////////////////////////////////////////////////////////////
    // Read port
    property p_rdIdle; clkEn && !regRd |=> regRdData == 8'h00; endproperty
    a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
    property p_unmapped;
        clkEn && regRd && (regAddr == `TMR_IRQACK_OFS) |=> regRdData == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not 0");
    property p_ctlRead;
        clkEn && regRd && (regAddr == `TMR_CTRL_OFS) |=>
            regRdData[7] == $past(timer1Irq) && regRdData[5] == $past(timer0Irq);
    endproperty
    a_ctlRead: assert property (p_ctlRead) else $error("flag bits mismatch");
    property p_reload;
        clkEn && regWr && (regAddr == `TMR_R0LOW_OFS) ##2
        clkEn && regRd && (regAddr == `TMR_R0LOW_OFS) |=> regRdData == $past(regWrData, 3);
    endproperty
    a_reload: assert property (p_reload) else $error("reload readback wrong");

    ////////////////////////////////////////////////////////////////////////////
    // Flags
    property p_tf0Hold; clkEn && timer0Irq && !timer0Ack && !ctlWr |=> timer0Irq; endproperty
    a_tf0Hold: assert property (p_tf0Hold) else $error("timer 0 flag lost");
    property p_tf1Hold; clkEn && timer1Irq && !timer1Ack && !ctlWr |=> timer1Irq; endproperty
    a_tf1Hold: assert property (p_tf1Hold) else $error("timer 1 flag lost");
    property p_swSet0; ctlWr && regWrData[5] && !timer0Ack |=> timer0Irq; endproperty
    a_swSet0: assert property (p_swSet0) else $error("timer 0 flag not written");
    property p_swSet1; ctlWr && regWrData[7] && !timer1Ack |=> timer1Irq; endproperty
    a_swSet1: assert property (p_swSet1) else $error("timer 1 flag not written");
    property p_freeze;
        !clkEn |=> $stable(regRdData) && $stable(timer0Irq) && $stable(timer1Irq);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule

bind dual_timer_counter_modes dual_timer_checker #(.ADDR_W(ADDR_W)) chk_u (
    .clk(clk), .reset_n(reset_n), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .timer0Ack(timer0Ack), .timer1Ack(timer1Ack),
    .timer0Irq(timer0Irq), .timer1Irq(timer1Irq));

// ===== tb/dual_timer_counter_modes_bench.sv
// Self-checking bench of the dual timer/counter
`timescale 1ns/1ps
`include "dual_timer_map.vh"
module dual_timer_counter_modes_bench;
    logic        clk = 1'b0;        // 100 MHz clock
    logic        reset_n = 1'b0;    // Reset, active low
    logic        clkEn = 1'b1;      // Global run enable
    logic [11:0] regAddr = '0;      // Register address
    logic [7:0]  regWrData = '0;    // Write data
    logic        regWr = 1'b0;      // Write strobe
    logic        regRd = 1'b0;      // Read strobe
    wire  [7:0]  regRdData;         // Read data from the block
    logic [7:0]  rdv;               // Last value read
    logic [1:0]  cntPin = 2'h3;     // Count inputs, idle high
    logic [1:0]  extPin = 2'h3;     // Interrupt pins, idle high
    logic [3:0]  acks = '0;         // Irq0, irq1, timer0, timer1 acks
    wire  [1:0]  tmrIrq;            // Timer flag levels
    wire  [1:0]  extReq;            // External request levels
    int          fails = 0;         // Mismatch count
    int          checked = 0;       // Comparison count
    int          cycles = 0;        // Hang guard
    int          c, m, ps;          // Loop and cycle scratch

    // Clock and hang guard; ceiling well above the longest rate sweep
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            fails++;
            end_sim();
        end
    end

    dual_timer_counter_modes dut_u (
        .clk(clk), .reset_n(reset_n), .clkEn(clkEn), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .countPin0(cntPin[0]), .countPin1(cntPin[1]),
        .extIrq0Pin(extPin[0]), .extIrq1Pin(extPin[1]),
        .irq0Ack(acks[0]), .irq1Ack(acks[1]), .timer0Ack(acks[2]), .timer1Ack(acks[3]),
        .timer0Irq(tmrIrq[0]), .timer1Irq(tmrIrq[1]),
        .extIrq0Req(extReq[0]), .extIrq1Req(extReq[1]));

    ////////////////////////////////////////////////////////////////////////////
    // Bus and pin tasks
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk) begin regWr <= 1'b1; regAddr <= a; regWrData <= d; end
        @(posedge clk) regWr <= 1'b0;
        #1;                         // Written value settles before any compare
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clk) begin regRd <= 1'b1; regAddr <= a; end
        @(posedge clk) regRd <= 1'b0;
        #1 rdv = regRdData;         // Data stands only in this cycle
    endtask
    task automatic ack(input int i);
        @(posedge clk) acks[i] <= 1'b1;
        @(posedge clk) acks <= '0;
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Cycles until a timer flag is seen high, bounded
    task automatic waitFlag(input int t, output int cyc);
        cyc = 0;
        do begin
            @(posedge clk);
            #1 cyc++;
        end while (tmrIrq[t] !== 1'b1 && cyc < 3000);
        if (cyc >= 3000) chk(16'h0, 16'h1);
    endtask
    // Three falling edges, each level held well past the sampling window
    task automatic cntPulses();
        repeat (3) begin
            @(posedge clk) cntPin[0] <= 1'b0;
            repeat (6) @(posedge clk);
            cntPin[0] <= 1'b1;
            repeat (5) @(posedge clk);
        end
    endtask
    task automatic end_sim();
        if (fails == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        rd(`TMR_CTRL_OFS); chk(16'(rdv), 16'h00);
        rd(`TMR_IRQACK_OFS); chk(16'(rdv), 16'h00);
        wr(`TMR_CTRL_OFS, 8'ha0); chk(16'(tmrIrq), 16'h3);
        ack(2); ack(3); chk(16'(tmrIrq), 16'h0);
        // Rate sweep over reload modes and every prescale code
        for (m = 0; m < 2; m++) begin
            for (ps = 0; ps < 4; ps++) begin
                wr(`TMR_MODE_OFS, m ? 8'h02 : 8'h00);
                wr(`TMR_PRESCALE_OFS, 8'(ps << 2));
                wr(`TMR_R0HIGH_OFS, 8'hff);
                wr(`TMR_R0LOW_OFS, 8'hfc);
                rd(`TMR_R0LOW_OFS); chk(16'(rdv), 16'hfc);
                wr(`TMR_T0HIGH_OFS, m ? 8'h5a : 8'hff);
                wr(`TMR_T0LOW_OFS, 8'hfc);
                wr(`TMR_CTRL_OFS, 8'h10);
                waitFlag(0, c);
                ack(2);
                waitFlag(0, c);
                // Ack handshake hides two cycles of the period from the count
                chk(16'(c + 2), 16'(16 << (ps == 3 ? 0 : 2 * ps)));
                rd(`TMR_T0HIGH_OFS);
                chk(16'(rdv), m ? 16'h5a : 16'hff);
                wr(`TMR_CTRL_OFS, 8'h00);
                ack(2);
            end
        end
        // Timer 1 free-running; toggle enable masks its flag
        wr(`TMR_PRESCALE_OFS, 8'h00);
        wr(`TMR_MODE_OFS, 8'h10);
        wr(`TMR_R1HIGH_OFS, 8'h77);
        wr(`TMR_OUTSTAT_OFS, 8'h04);
        wr(`TMR_T1HIGH_OFS, 8'hff);
        wr(`TMR_T1LOW_OFS, 8'hfe);
        wr(`TMR_CTRL_OFS, 8'h40);
        repeat (20) @(posedge clk);
        clkEn <= 1'b0;              // Brief freeze mid-count
        repeat (8) @(posedge clk);
        clkEn <= 1'b1;
        repeat (12) @(posedge clk);
        #1 chk(16'(tmrIrq[1]), 16'h0);
        wr(`TMR_OUTSTAT_OFS, 8'h00);
        wr(`TMR_T1HIGH_OFS, 8'hff);
        wr(`TMR_T1LOW_OFS, 8'hfe);
        waitFlag(1, c);
        rd(`TMR_T1HIGH_OFS); chk(16'(rdv), 16'h00);
        wr(`TMR_MODE_OFS, 8'h30);
        ack(3); chk(16'(tmrIrq[1]), 16'h0);
        // Split mode: high byte of timer 0 runs on the timer 1 run bit
        wr(`TMR_MODE_OFS, 8'h33);
        wr(`TMR_T1LOW_OFS, 8'h21);
        wr(`TMR_T0LOW_OFS, 8'h00);
        wr(`TMR_T0HIGH_OFS, 8'hf0);
        wr(`TMR_CTRL_OFS, 8'h40);
        waitFlag(1, c);
        chk(16'(c < 80), 16'h1);
        chk(16'(tmrIrq[0]), 16'h0);
        rd(`TMR_T1LOW_OFS); chk(16'(rdv), 16'h21);
        rd(`TMR_T0LOW_OFS); chk(16'(rdv), 16'h00);
        wr(`TMR_MODE_OFS, 8'h13);
        repeat (40) @(posedge clk);
        rd(`TMR_T1LOW_OFS); chk(16'(rdv > 8'h21), 16'h1);
        // Gated event counting on timer 0
        wr(`TMR_CTRL_OFS, 8'h00);
        ack(3);
        wr(`TMR_MODE_OFS, 8'h0d);
        wr(`TMR_T0LOW_OFS, 8'h00);
        wr(`TMR_CTRL_OFS, 8'h10);
        @(posedge clk) extPin[0] <= 1'b0;
        cntPulses();
        rd(`TMR_T0LOW_OFS); chk(16'(rdv), 16'h00);
        @(posedge clk) extPin[0] <= 1'b1;
        cntPulses();
        rd(`TMR_T0LOW_OFS); chk(16'(rdv), 16'h03);
        // Edge-triggered external interrupt flags
        wr(`TMR_CTRL_OFS, 8'h05);
        @(posedge clk) extPin <= 2'h0;
        repeat (8) @(posedge clk);
        #1 chk(16'(extReq), 16'h3);
        rd(`TMR_CTRL_OFS); chk(16'(rdv), 16'h0f);
        ack(0); chk(16'(extReq), 16'h2);
        ack(1); chk(16'(extReq), 16'h0);
        // Timer 1 reload modes; stopped two cycles after overflow, before the next tick
        for (m = 0; m < 2; m++) begin
            wr(`TMR_MODE_OFS, m ? 8'h20 : 8'h00);
            wr(`TMR_R1HIGH_OFS, 8'h9c);
            wr(`TMR_R1LOW_OFS, 8'h80);
            wr(`TMR_T1HIGH_OFS, m ? 8'h3c : 8'hff);
            wr(`TMR_T1LOW_OFS, 8'hfe);
            wr(`TMR_CTRL_OFS, 8'h40);
            waitFlag(1, c);
            wr(`TMR_CTRL_OFS, 8'h00);
            rd(`TMR_T1HIGH_OFS); chk(16'(rdv), m ? 16'h3c : 16'h9c);
            rd(`TMR_T1LOW_OFS); chk(16'(rdv), 16'h80);
            ack(3); chk(16'(tmrIrq[1]), 16'h0);
        end
        end_sim();
    end
endmodule
